/* File: verilog/mode_pkg.sv */
// Constants, field layouts and types shared by the privilege mode logic
package mode_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register indices on the plain register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h1;
  localparam logic [3:0] REG_FAULT = 4'h2;

  // Status word bit positions
  localparam int BIT_ISA4 = 31;
  localparam int BIT_KWIDE = 7;
  localparam int BIT_SWIDE = 6;
  localparam int BIT_UWIDE = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 3;
  localparam int BIT_ERL = 2;
  localparam int BIT_EXL = 1;

  // Status word reset value and writable bits
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_WMASK = 32'h8000_00FE;

  // Privilege select encodings
  localparam logic [1:0] SEL_KERNEL = 2'h0;
  localparam logic [1:0] SEL_SUPER = 2'h1;
  localparam logic [1:0] SEL_USER = 2'h2;

  // Mode readback register fields
  localparam int MODE_PRIV_LO = 0;
  localparam int MODE_WIDE = 4;
  localparam int MODE_ISA3 = 5;
  localparam int MODE_ISA4 = 6;
  localparam int MODE_REGS = 7;
  localparam int MODE_FORCED = 8;

  // Fault register fields
  localparam int FAULT_FLAG = 0;
  localparam int FAULT_CNT_LO = 8;
  localparam int FAULT_CNT_W = 8;

  // Operating privilege, one-hot
  typedef enum logic [2:0] {
    PRIV_KERNEL = 3'b001,
    PRIV_SUPER = 3'b010,
    PRIV_USER = 3'b100
  } priv_t;

  // Mode bits of the status word
  typedef struct packed {
    logic user_isa4_enable;
    logic kernel_wide_enable;
    logic supervisor_wide_enable;
    logic user_wide_enable;
    logic [1:0] privilege_select;
    logic error_level_flag;
    logic exception_level_flag;
  } status_t;

  // Decoded operating state handed to the pipeline
  typedef struct packed {
    priv_t priv;
    logic wide_addr;
    logic isa3_en;
    logic isa4_en;
    logic full_reg_access;
    logic level_forced;
  } mode_t;

  // Decoded state during reset: kernel, 32-bit, both sets, full access
  localparam mode_t MODE_RESET = '{priv: PRIV_KERNEL, wide_addr: 1'b0, isa3_en: 1'b1,
    isa4_en: 1'b1, full_reg_access: 1'b1, level_forced: 1'b0};

  // Pick mode bits out of a status word
  function automatic status_t unpack_status(input logic [31:0] w);
    status_t s;
    s.user_isa4_enable = w[BIT_ISA4];
    s.kernel_wide_enable = w[BIT_KWIDE];
    s.supervisor_wide_enable = w[BIT_SWIDE];
    s.user_wide_enable = w[BIT_UWIDE];
    s.privilege_select = w[SEL_HI:SEL_LO];
    s.error_level_flag = w[BIT_ERL];
    s.exception_level_flag = w[BIT_EXL];
    return s;
  endfunction

  // Place mode bits back into a status word, other bits zero
  function automatic logic [31:0] pack_status(input status_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_ISA4] = s.user_isa4_enable;
    w[BIT_KWIDE] = s.kernel_wide_enable;
    w[BIT_SWIDE] = s.supervisor_wide_enable;
    w[BIT_UWIDE] = s.user_wide_enable;
    w[SEL_HI:SEL_LO] = s.privilege_select;
    w[BIT_ERL] = s.error_level_flag;
    w[BIT_EXL] = s.exception_level_flag;
    return w;
  endfunction

endpackage

/* File: verilog/mode_decode.sv */
// Combinational decode of status mode bits into privilege and enables
`timescale 1ns/1ps
module mode_decode (
  // Status mode bits
  input mode_pkg::status_t st,
  // Decoded state
  output mode_pkg::mode_t md
);

  wire err_lvl;
  wire exc_lvl;
  wire forced;
  wire sel_kernel;
  wire sel_super;
  wire sel_user;
  wire is_kernel;

  // Error level masks the exception flag entirely
  assign err_lvl = st.error_level_flag;
  assign exc_lvl = !st.error_level_flag && st.exception_level_flag;
  assign forced = err_lvl || exc_lvl;

  // Privilege select applies only with both level flags clear
  assign sel_kernel = !forced && (st.privilege_select == mode_pkg::SEL_KERNEL);
  assign sel_super = !forced && (st.privilege_select == mode_pkg::SEL_SUPER);
  // Select values 10 and the undefined 11 both give user
  assign sel_user = !forced && st.privilege_select[1];
  assign is_kernel = forced || sel_kernel;

  // Privilege level, kernel above supervisor above user
  assign md.priv = is_kernel ? mode_pkg::PRIV_KERNEL :
                   sel_super ? mode_pkg::PRIV_SUPER : mode_pkg::PRIV_USER;

  // Address width per mode; levels use the kernel bit alone
  assign md.wide_addr = is_kernel ? st.kernel_wide_enable :
                        sel_super ? st.supervisor_wide_enable :
                        st.user_wide_enable;

  // Level-III set follows the wide bit outside kernel
  assign md.isa3_en = is_kernel || (sel_super && st.supervisor_wide_enable) ||
                      (sel_user && st.user_wide_enable);

  // Level-IV set: always in kernel and supervisor, user needs extension bit
  assign md.isa4_en = is_kernel || sel_super ||
                      (sel_user && st.user_isa4_enable);

  // Full register access only with kernel privilege
  assign md.full_reg_access = is_kernel;
  assign md.level_forced = forced;

endmodule

/* File: verilog/priv_mode_ctrl.sv */
// Privilege and addressing mode controller with status register port
//
// Summary of operation
// - Three privilege levels: kernel, supervisor, user.
// - Select field chooses mode when levels clear.
// - Either level flag forces kernel privilege.
// - Error level makes exception flag don't-care.
// - Mode bits sit at fixed status positions.
// - Output selects 32-bit or 64-bit addressing.
// - Kernel: wide bit sets width, all sets.
// - Supervisor wide bit gives 64-bit and level-III.
// - Supervisor always has level-IV enabled.
// - User wide bit gives 64-bit and level-III.
// - User level-IV only with extension bit.
// - Levels: both sets, kernel wide bit width.
// - Only kernel may modify every register.
// - Mode bits can limit usable instruction sets.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module priv_mode_ctrl (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register port
  input wire logic [mode_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mode_pkg::DATA_W-1:0] reg_rdata,
  // Core events
  input wire logic exc_enter,
  input wire logic err_enter,
  input wire logic exc_return,
  // Decoded mode to the pipeline
  output mode_pkg::mode_t mode_out,
  output logic status_write_refused
);

  // Stored state
  mode_pkg::status_t status_r;
  mode_pkg::status_t status_nxt;
  mode_pkg::mode_t mode_r;
  mode_pkg::mode_t mode_nxt;
  logic fault_r;
  logic fault_nxt;
  logic [mode_pkg::FAULT_CNT_W-1:0] fault_cnt_r;
  logic [mode_pkg::FAULT_CNT_W-1:0] fault_cnt_nxt;
  logic refused_r;
  logic [mode_pkg::DATA_W-1:0] rdata_r;
  logic [mode_pkg::DATA_W-1:0] rdata_nxt;

  // Saturating increment for the refused-write counter
  function automatic logic [mode_pkg::FAULT_CNT_W-1:0] sat_inc(
    input logic [mode_pkg::FAULT_CNT_W-1:0] v
  );
    logic [mode_pkg::FAULT_CNT_W-1:0] r;
    r = v;
    if (v != {mode_pkg::FAULT_CNT_W{1'b1}}) begin
      r = v + {{(mode_pkg::FAULT_CNT_W-1){1'b0}}, 1'b1};
    end
    return r;
  endfunction

  // Address decode
  wire hit_status;
  wire hit_mode;
  wire hit_fault;
  assign hit_status = (reg_addr == mode_pkg::REG_STATUS);
  assign hit_mode = (reg_addr == mode_pkg::REG_MODE);
  assign hit_fault = (reg_addr == mode_pkg::REG_FAULT);

  // Current privilege as seen by software on the port
  wire kernel_now;
  assign kernel_now = mode_r.full_reg_access;

  // Write qualification: only kernel may change mode bits
  wire wr_status;
  wire wr_status_ok;
  wire wr_fault;
  wire wr_fault_ok;
  wire wr_refused;
  assign wr_status = reg_wr && hit_status;
  assign wr_fault = reg_wr && hit_fault;
  assign wr_status_ok = wr_status && kernel_now;
  assign wr_fault_ok = wr_fault && kernel_now;
  assign wr_refused = (wr_status || wr_fault) && !kernel_now;

  // Software view of the status word after an accepted write
  wire [mode_pkg::DATA_W-1:0] wr_masked;
  mode_pkg::status_t sw_status;
  assign wr_masked = reg_wdata & mode_pkg::STATUS_WMASK;
  assign sw_status = wr_status_ok ? mode_pkg::unpack_status(wr_masked) : status_r;

  // Return from a level clears error level first, else exception level
  wire ret_err;
  wire ret_exc;
  assign ret_err = exc_return && status_r.error_level_flag;
  assign ret_exc = exc_return && !status_r.error_level_flag;

  // Hardware entry sets a level flag and wins over any clear
  wire erl_nxt;
  wire exl_nxt;
  assign erl_nxt = err_enter || (sw_status.error_level_flag && !ret_err);
  assign exl_nxt = exc_enter || (sw_status.exception_level_flag && !ret_exc);

  // Next status word: written fields plus level flag updates
  always_comb begin
    status_nxt = sw_status;
    status_nxt.error_level_flag = erl_nxt;
    status_nxt.exception_level_flag = exl_nxt;
  end

  // Decode from the next status so outputs change on the same edge as the status register
  mode_decode u_decode (
    .st(status_nxt),
    .md(mode_nxt)
  );

  // Sticky fault flag: a new refusal wins over a clear
  wire fault_clr;
  assign fault_clr = wr_fault_ok && reg_wdata[mode_pkg::FAULT_FLAG];
  assign fault_nxt = wr_refused || (fault_r && !fault_clr);

  // Counter of refused writes, cleared with the flag
  always_comb begin
    fault_cnt_nxt = fault_cnt_r;
    if (fault_clr) begin
      fault_cnt_nxt = {mode_pkg::FAULT_CNT_W{1'b0}};
    end
    if (wr_refused) begin
      fault_cnt_nxt = sat_inc(fault_clr ? {mode_pkg::FAULT_CNT_W{1'b0}} : fault_cnt_r);
    end
  end

  // Privilege field for the mode readback word
  logic [2:0] priv_code;
  always_comb begin
    case (mode_r.priv)
      mode_pkg::PRIV_KERNEL: priv_code = 3'h1;
      mode_pkg::PRIV_SUPER: priv_code = 3'h2;
      mode_pkg::PRIV_USER: priv_code = 3'h4;
      default: priv_code = 3'h0;
    endcase
  end

  // Mode readback word showing the current decoded state
  logic [mode_pkg::DATA_W-1:0] mode_word;
  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[mode_pkg::MODE_PRIV_LO +: 3] = priv_code;
    mode_word[mode_pkg::MODE_WIDE] = mode_r.wide_addr;
    mode_word[mode_pkg::MODE_ISA3] = mode_r.isa3_en;
    mode_word[mode_pkg::MODE_ISA4] = mode_r.isa4_en;
    mode_word[mode_pkg::MODE_REGS] = mode_r.full_reg_access;
    mode_word[mode_pkg::MODE_FORCED] = mode_r.level_forced;
  end

  // Fault readback word
  logic [mode_pkg::DATA_W-1:0] fault_word;
  always_comb begin
    fault_word = 32'h0000_0000;
    fault_word[mode_pkg::FAULT_FLAG] = fault_r;
    fault_word[mode_pkg::FAULT_CNT_LO +: mode_pkg::FAULT_CNT_W] = fault_cnt_r;
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (hit_status) begin
        rdata_nxt = mode_pkg::pack_status(status_r);
      end else if (hit_mode) begin
        rdata_nxt = mode_word;
      end else if (hit_fault) begin
        rdata_nxt = fault_word;
      end
    end
  end

  // Status register and decoded mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= mode_pkg::status_t'(8'h00);
      mode_r <= mode_pkg::MODE_RESET;
    end else if (clk_en) begin
      status_r <= status_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Fault flag, counter and refusal pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_r <= 1'b0;
      fault_cnt_r <= {mode_pkg::FAULT_CNT_W{1'b0}};
      refused_r <= 1'b0;
    end else if (clk_en) begin
      fault_r <= fault_nxt;
      fault_cnt_r <= fault_cnt_nxt;
      refused_r <= wr_refused;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_r;
  assign mode_out = mode_r;
  assign status_write_refused = refused_r;

endmodule

/* File: tb/core_model.sv */
// Core side model raising level entry and return events
`timescale 1ns/1ps
module core_model (
  // Clock
  input wire logic sys_clk,
  // Events to the controller
  output logic exc_enter,
  output logic err_enter,
  output logic exc_return
);
  // Events idle low between pulses
  initial begin
    exc_enter = 1'b0;
    err_enter = 1'b0;
    exc_return = 1'b0;
  end
  // One-cycle pulse; bits are exception, error, return
  task automatic fire(input logic [2:0] k);
    @(posedge sys_clk);
    exc_enter <= k[0];
    err_enter <= k[1];
    exc_return <= k[2];
    @(posedge sys_clk);
    {exc_enter, err_enter, exc_return} <= 3'h0;
    #1;
  endtask
endmodule

/* File: tb/priv_mode_properties.sv */
// Concurrent checks on the privilege mode controller ports
`timescale 1ns/1ps
module priv_mode_checks (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register port
  input wire logic [mode_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mode_pkg::DATA_W-1:0] reg_rdata,
  // Core events and decoded mode
  input wire logic exc_enter,
  input wire logic err_enter,
  input wire logic exc_return,
  input mode_pkg::mode_t mode_out,
  input wire logic status_write_refused
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Status write from a lower level, no core event beside it
  sequence low_wr;
    clk_en && reg_wr && reg_addr == mode_pkg::REG_STATUS && !exc_enter && !err_enter &&
      !exc_return && mode_out.priv != mode_pkg::PRIV_KERNEL;
  endsequence
  // Entry to exception or error level
  sequence level_entry;
    clk_en && (exc_enter || err_enter);
  endsequence
  onehot_priv_a:
    assert property ($onehot(mode_out.priv)) else $error("privilege not one-hot");
  forced_kernel_a:
    assert property (mode_out.level_forced |-> mode_out.priv == mode_pkg::PRIV_KERNEL &&
      mode_out.isa3_en && mode_out.isa4_en) else $error("level not kernel");
  kernel_access_a:
    assert property (mode_out.full_reg_access == (mode_out.priv == mode_pkg::PRIV_KERNEL))
      else $error("access flag wrong");
  kernel_sets_a:
    assert property (mode_out.priv == mode_pkg::PRIV_KERNEL |-> mode_out.isa3_en &&
      mode_out.isa4_en) else $error("kernel set off");
  super_isa4_a:
    assert property (mode_out.priv == mode_pkg::PRIV_SUPER |-> mode_out.isa4_en)
      else $error("supervisor set four off");
  wide_isa3_a:
    assert property (mode_out.priv != mode_pkg::PRIV_KERNEL |->
      mode_out.wide_addr == mode_out.isa3_en) else $error("width and set three differ");
  entry_forces_a:
    assert property (level_entry |=> mode_out.level_forced &&
      mode_out.priv == mode_pkg::PRIV_KERNEL) else $error("entry not forced");
  refuse_low_a:
    assert property (low_wr |=> status_write_refused && $stable(mode_out))
      else $error("low write not refused");
  rdata_idle_a:
    assert property (clk_en && !reg_rd |=> reg_rdata == '0) else $error("read data not idle");
endmodule

bind priv_mode_ctrl priv_mode_checks u_chk (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .exc_enter(exc_enter), .err_enter(err_enter),
  .exc_return(exc_return), .mode_out(mode_out), .status_write_refused(status_write_refused));

/* File: tb/test_priv_mode_ctrl.sv */
// Self-checking bench for the privilege mode controller
`timescale 1ns/1ps
module test_priv_mode_ctrl;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic exc_enter, err_enter, exc_return, status_write_refused;
  mode_pkg::mode_t mode_out;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] vec [13] = '{32'h0000_00D0, 32'h8000_00D0, 32'h0000_0030, 32'h8000_0030,
    32'h8000_00A8, 32'h0000_0048, 32'h0F00_0060, 32'h0000_0080, 32'h0000_0072,
    32'h0000_0092, 32'h0000_006E, 32'h8000_0094, 32'h0000_0018};

  priv_mode_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .exc_enter(exc_enter), .err_enter(err_enter), .exc_return(exc_return),
    .mode_out(mode_out), .status_write_refused(status_write_refused));
  core_model core (.sys_clk(sys_clk), .exc_enter(exc_enter), .err_enter(err_enter),
    .exc_return(exc_return));

  // Clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask
  // Expected mode byte: priv, wide, set three, set four, access, forced
  function automatic logic [7:0] exp_mode(input logic [31:0] w);
    if (w[2] || w[1]) return {3'h1, w[7], 4'hF};
    if (w[4:3] == 2'h0) return {3'h1, w[7], 4'hE};
    if (w[4:3] == 2'h1) return {3'h2, w[6], w[6], 3'h4};
    return {3'h4, w[5], w[5], w[31], 2'h0};
  endfunction

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    check({24'h0, mode_out}, 32'h0000_002E);
    for (int i = 0; i < 13; i++) begin
      core.fire(3'h1);
      wr(mode_pkg::REG_STATUS, vec[i]);
      check({24'h0, mode_out}, {24'h0, exp_mode(vec[i])});
      rd(mode_pkg::REG_STATUS);
      check(rd_v, vec[i] & mode_pkg::STATUS_WMASK);
    end
    $display("decode table test done");
    wr(mode_pkg::REG_STATUS, 32'h0000_0000);
    check({31'h0, status_write_refused}, 32'h1);
    check({24'h0, mode_out}, 32'h0000_0080);
    wr(mode_pkg::REG_FAULT, 32'h0000_0001);
    rd(mode_pkg::REG_FAULT);
    check(rd_v, 32'h0000_0201);
    rd(mode_pkg::REG_MODE);
    check(rd_v, 32'h0000_0004);
    rd(4'hF);
    check(rd_v, 32'h0000_0000);
    $display("refusal test done");
    core.fire(3'h1);
    check({24'h0, mode_out}, 32'h0000_002F);
    core.fire(3'h4);
    check({24'h0, mode_out}, 32'h0000_0080);
    core.fire(3'h3);
    core.fire(3'h4);
    check({24'h0, mode_out}, 32'h0000_002F);
    core.fire(3'h4);
    check({24'h0, mode_out}, 32'h0000_0080);
    core.fire(3'h1);
    wr(mode_pkg::REG_FAULT, 32'h0000_0001);
    check({31'h0, status_write_refused}, 32'h0);
    rd(mode_pkg::REG_FAULT);
    check(rd_v, 32'h0000_0000);
    $display("event test done");
    // Enable low: a return is lost and the decoded mode holds
    @(posedge sys_clk);
    clk_en <= 1'b0;
    core.fire(3'h4);
    check({24'h0, mode_out}, 32'h0000_002F);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    core.fire(3'h4);
    check({24'h0, mode_out}, 32'h0000_0080);
    $display("enable test done");
    close_out();
  end
endmodule
